// file: inc/ssrb_pkg.sv
package ssrb_pkg;
  // register offsets (byte address of the most significant byte)
  localparam logic [5:0] OFS_EWR_ADDR  = 6'h02;
  localparam logic [5:0] OFS_EWR_UPPER = 6'h04;
  localparam logic [5:0] OFS_EWR_LOWER = 6'h06;
  localparam logic [5:0] OFS_EWR_CTRL  = 6'h08;
  localparam logic [5:0] OFS_ERD_ADDR  = 6'h0A;
  localparam logic [5:0] OFS_ERD_CTRL  = 6'h0C;
  localparam logic [5:0] OFS_ERD_UPPER = 6'h0E;
  localparam logic [5:0] OFS_ERD_LOWER = 6'h10;
  localparam logic [5:0] OFS_ACT_CTRL  = 6'h1E;
  localparam logic [5:0] OFS_ANGLE     = 6'h20;
  localparam logic [5:0] OFS_COND      = 6'h22;
  localparam logic [5:0] OFS_FAULTS    = 6'h24;
  localparam logic [5:0] OFS_WARNS     = 6'h26;
  localparam logic [5:0] OFS_KEY       = 6'h3C;

  // field positions
  localparam int BIT_LAUNCH    = 15;
  localparam int BIT_BUSY      = 8;
  localparam int BIT_DONE      = 0;
  localparam int BIT_WIPE_ERR  = 8;
  localparam int BIT_WIPE_WARN = 9;
  localparam int BIT_WIPE_DONE = 10;
  localparam int BIT_PARITY    = 12;
  localparam int BIT_UV_SUM    = 13;
  localparam int BIT_FAULT_SUM = 14;
  localparam int BIT_ROT       = 7;
  localparam int BIT_SDN       = 5;
  localparam int BIT_BDN       = 4;
  localparam int BIT_LBR       = 3;
  localparam int BIT_TRANSDUCER_SELFTEST_RUNNING      = 2;
  localparam int BIT_BIP       = 1;
  localparam int BIT_AOK       = 0;
  localparam int BIT_E_RST     = 0;
  localparam int BIT_E_MSL     = 1;
  localparam int BIT_E_UVA     = 2;
  localparam int BIT_E_UVD     = 3;
  localparam int BIT_E_STF     = 10;
  localparam int BIT_E_WAR     = 11;
  localparam int BIT_W_OVERLAP = 2;
  localparam int BIT_W_XFAIL   = 7;

  // fixed upper nibbles that tag the status words
  localparam logic [3:0] TAG_COND   = 4'h8;
  localparam logic [3:0] TAG_FAULTS = 4'hA;
  localparam logic [3:0] TAG_WARNS  = 4'hB;

  // extended address ranges
  localparam logic [7:0] NV_LO = 8'h00;
  localparam logic [7:0] NV_HI = 8'h1F;
  localparam logic [7:0] SH_LO = 8'h40;
  localparam logic [7:0] SH_HI = 8'h5F;

  // action select codes and trigger bytes
  localparam logic [3:0] ACT_NONE    = 4'h0;
  localparam logic [3:0] ACT_MARG_LO = 4'h1;
  localparam logic [3:0] ACT_MARG_HI = 4'h2;
  localparam logic [3:0] ACT_RELOAD  = 4'h5;
  localparam logic [3:0] ACT_HRESET  = 4'h7;
  localparam logic [3:0] ACT_TST_TR  = 4'h9;
  localparam logic [3:0] ACT_TST_LG  = 4'hA;
  localparam logic [3:0] ACT_TST_BO  = 4'hB;
  localparam logic [7:0] TRIG_TEST   = 8'hB9;
  localparam logic [7:0] TRIG_NVM    = 8'hA5;
  localparam logic [7:0] TRIG_RESET  = 8'h5A;

  // unlock key sequence
  localparam logic [39:0] KEY_SEQ = 40'h00_2781_1F77;

  // timing
  localparam int CLK_NS        = 100;
  localparam int NV_WRITE_MS   = 24;
  localparam int NV_WRITE_CYC  = (NV_WRITE_MS * 1000000) / CLK_NS;
  localparam int NV_READ_NS    = 2000;
  localparam int NV_READ_CYC   = (NV_READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACTION_CYC    = 64;
  localparam int BOOT_CYC      = 32;
  localparam logic [11:0] ROT_HYST = 12'h008;

  // serial controller register request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  addr;
    logic [15:0] wdata;
  } ssrb_req_s;

  typedef enum logic [1:0] {ACT_IDLE = 2'b00, ACT_RUN = 2'b01, ACT_FIN = 2'b11} ssrb_act_e;
endpackage

// file: hdl/ssrb_top.sv
// Overview of operation
// - extended writes: 00-1F nvm, 40-5F shadow, unlocked only
// - nvm extended write lasts about 24 ms
// - write launch sets busy, clears done, reads zero
// - extended read: same ranges, nvm 2 us
// - self-tests 1010/1011, reload or boot clear read address
// - read launch sets busy, clears done, reads zero
// - read result halves valid once done is set
// - trigger byte B9/A5/5A, always reads zero
// - error/warning wipe clears only previously read flags
// - bit 10 clears special/boot done; strobes read zero
// - select 0000 none, 0001/0010 margining
// - reload and hard reset need unlock plus trigger
// - self-tests 1001/1010/1011 start on B9
// - special done drops on trigger, rises, select clears
// - angle word holds 12-bit unsigned angle
// - parity bit makes word odd weight
// - undervoltage summary is masked realtime or
// - fault summary: any unmasked error or warning
// - direction bit from angle with hysteresis
// - error flags sticky until read, then cleared by wipe
// - reset flag on power-on and hard reset only
// - launch while busy raises overlap warning
// - five key writes unlock; key field reads zero
// - failed extended write raises command failure warning
module ssrb_top
  import ssrb_pkg::*;
#(
  parameter int NV_WR_CYCLES = NV_WRITE_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire ssrb_req_s   reg_req,
  input  wire logic [11:0] angle_in,
  input  wire logic        angle_lock,
  input  wire logic        field_low_in,
  input  wire logic        analog_uv_pin,
  input  wire logic        digital_uv_pin,
  input  wire logic        selftest_fail,
  output logic [15:0]      reg_rdata,
  output logic             reg_rvalid,
  output logic [1:0]       margin_mode,
  output logic             core_reset_pulse
);
  localparam int CW = 18;

  // memories: nonvolatile and shadow, 32 words of 32 bits each
  logic [31:0] nv_mem [0:31];
  logic [31:0] sh_mem [0:31];

  logic [7:0]  ewr_addr_r;
  logic [15:0] ext_write_upper_half_r;
  logic [15:0] ext_write_lower_half_r;
  logic [7:0]  erd_addr_r;
  logic [15:0] ext_read_upper_half_r;
  logic [15:0] ext_read_lower_half_r;
  logic        ext_write_busy_r;
  logic        ext_write_done_r;
  logic        ext_read_busy_r;
  logic        ext_read_done_r;
  logic [CW-1:0] ext_cnt_r;
  logic        ext_wr_nv_r;
  logic        ext_rd_nv_r;
  logic [3:0]  act_sel_r;
  ssrb_act_e   act_state_r;
  logic [CW-1:0] act_cnt_r;
  logic        action_done_r;
  logic        boot_running_r;
  logic        boot_done_r;
  logic [CW-1:0] boot_cnt_r;
  logic [15:0] err_r;
  logic [15:0] err_seen_r;
  logic [15:0] warn_r;
  logic [15:0] warn_seen_r;
  logic        user_unlocked_flag_r;
  logic [2:0]  key_idx_r;
  logic        turn_direction_r;
  logic [11:0] rot_ref_r;
  logic [1:0]  uv_sync1_r;
  logic [1:0]  uv_sync2_r;

  // request decode
  logic wr_hit;
  logic rd_hit;
  assign wr_hit = reg_req.wr;
  assign rd_hit = reg_req.rd;
  logic launch_wr;
  logic launch_rd;
  logic ext_busy;
  logic launch_ext_write;
  logic launch_ext_read;
  assign ext_busy         = ext_write_busy_r | ext_read_busy_r;
  assign launch_wr        = wr_hit && reg_req.addr == OFS_EWR_CTRL && reg_req.wdata[BIT_LAUNCH];
  assign launch_rd        = wr_hit && reg_req.addr == OFS_ERD_CTRL && reg_req.wdata[BIT_LAUNCH];
  assign launch_ext_write = launch_wr && !ext_busy;
  assign launch_ext_read  = launch_rd && !ext_busy;

  function automatic logic in_nv(input logic [7:0] a);
    return a >= NV_LO && a <= NV_HI;
  endfunction
  function automatic logic in_sh(input logic [7:0] a);
    return a >= SH_LO && a <= SH_HI;
  endfunction

  // masks live in shadow word 0: low half for errors, high half for warnings
  logic [15:0] err_mask;
  logic [15:0] warn_mask;
  assign err_mask  = sh_mem[0][15:0];
  assign warn_mask = sh_mem[0][31:16];

  // undervoltage pins are asynchronous, two flops before use
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_uv_sync
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          uv_sync1_r[g] <= 1'b0;
          uv_sync2_r[g] <= 1'b0;
        end else begin
          uv_sync1_r[g] <= g == 0 ? analog_uv_pin : digital_uv_pin;
          uv_sync2_r[g] <= uv_sync1_r[g];
        end
      end
    end
  endgenerate

  // action trigger qualification: code must match the selected action
  logic [7:0] trig;
  logic       act_start;
  assign trig = reg_req.wdata[7:0];
  always_comb begin
    act_start = 1'b0;
    if (wr_hit && reg_req.addr == OFS_ACT_CTRL && act_state_r == ACT_IDLE) begin
      case (act_sel_r)
        ACT_RELOAD:  act_start = trig == TRIG_NVM && user_unlocked_flag_r;
        ACT_HRESET:  act_start = trig == TRIG_RESET && user_unlocked_flag_r;
        ACT_TST_TR,
        ACT_TST_LG,
        ACT_TST_BO:  act_start = trig == TRIG_TEST;
        default:     act_start = 1'b0;
      endcase
    end
  end

  logic act_end;
  logic hard_reset_end;
  logic nv_to_shadow;
  logic lbist_end;
  assign act_end        = act_state_r == ACT_RUN && act_cnt_r == CW'(ACTION_CYC - 1);
  assign hard_reset_end = act_end && act_sel_r == ACT_HRESET;
  assign lbist_end      = act_end && (act_sel_r == ACT_TST_LG || act_sel_r == ACT_TST_BO);
  assign nv_to_shadow   = (act_end && act_sel_r == ACT_RELOAD) ||
                          (boot_running_r && boot_cnt_r == CW'(BOOT_CYC - 1));

  // special action sequencer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      act_state_r   <= ACT_IDLE;
      act_cnt_r     <= '0;
      act_sel_r     <= ACT_NONE;
      action_done_r <= 1'b0;
    end else begin
      case (act_state_r)
        ACT_IDLE: begin
          if (act_start) begin
            act_state_r   <= ACT_RUN;
            action_done_r <= 1'b0;
            act_cnt_r     <= '0;
          end else if (wr_hit && reg_req.addr == OFS_ACT_CTRL) begin
            act_sel_r <= reg_req.wdata[15:12];
          end
        end
        ACT_RUN: begin
          act_cnt_r <= act_cnt_r + CW'(1);
          if (act_end) begin
            act_state_r <= ACT_FIN;
          end
        end
        ACT_FIN: begin
          act_state_r   <= ACT_IDLE;
          act_sel_r     <= ACT_NONE;
          action_done_r <= 1'b1;
        end
        default: act_state_r <= ACT_IDLE;
      endcase
      // a done event in the same cycle as a wipe wins
      if (wr_hit && reg_req.addr == OFS_ACT_CTRL && reg_req.wdata[BIT_WIPE_DONE] &&
          act_state_r != ACT_FIN) begin
        action_done_r <= 1'b0;
      end
    end
  end

  // boot sequence: copy nvm into shadow then report done
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      boot_running_r <= 1'b1;
      boot_cnt_r     <= '0;
      boot_done_r    <= 1'b0;
    end else if (hard_reset_end) begin
      boot_running_r <= 1'b1;
      boot_cnt_r     <= '0;
      boot_done_r    <= 1'b0;
    end else if (boot_running_r) begin
      boot_cnt_r <= boot_cnt_r + CW'(1);
      if (boot_cnt_r == CW'(BOOT_CYC - 1)) begin
        boot_running_r <= 1'b0;
        boot_done_r    <= 1'b1;
      end
    end else if (wr_hit && reg_req.addr == OFS_ACT_CTRL && reg_req.wdata[BIT_WIPE_DONE]) begin
      boot_done_r <= 1'b0;
    end
  end

  // extended address and data holding registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ewr_addr_r             <= 8'h00;
      ext_write_upper_half_r <= 16'h0000;
      ext_write_lower_half_r <= 16'h0000;
      erd_addr_r             <= 8'h00;
    end else begin
      if (wr_hit && reg_req.addr == OFS_EWR_ADDR) ewr_addr_r <= reg_req.wdata[7:0];
      if (wr_hit && reg_req.addr == OFS_EWR_UPPER) ext_write_upper_half_r <= reg_req.wdata;
      if (wr_hit && reg_req.addr == OFS_EWR_LOWER) ext_write_lower_half_r <= reg_req.wdata;
      if (lbist_end || nv_to_shadow) begin
        erd_addr_r <= 8'h00;
      end else if (wr_hit && reg_req.addr == OFS_ERD_ADDR) begin
        erd_addr_r <= reg_req.wdata[7:0];
      end
    end
  end

  // extended access engine, one access at a time
  logic write_ok;
  logic ext_end;
  assign write_ok = user_unlocked_flag_r && (in_nv(ewr_addr_r) || in_sh(ewr_addr_r));
  assign ext_end  = ext_cnt_r == '0;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ext_write_busy_r      <= 1'b0;
      ext_write_done_r      <= 1'b0;
      ext_read_busy_r       <= 1'b0;
      ext_read_done_r       <= 1'b0;
      ext_cnt_r             <= '0;
      ext_wr_nv_r           <= 1'b0;
      ext_rd_nv_r           <= 1'b0;
      ext_read_upper_half_r <= 16'h0000;
      ext_read_lower_half_r <= 16'h0000;
    end else begin
      if (launch_ext_write) begin
        ext_write_busy_r <= 1'b1;
        ext_write_done_r <= 1'b0;
        ext_wr_nv_r      <= write_ok && in_nv(ewr_addr_r);
        ext_cnt_r        <= (write_ok && in_nv(ewr_addr_r)) ? CW'(NV_WR_CYCLES - 1) : '0;
      end else if (launch_ext_read) begin
        ext_read_busy_r <= 1'b1;
        ext_read_done_r <= 1'b0;
        ext_rd_nv_r     <= in_nv(erd_addr_r);
        ext_cnt_r       <= in_nv(erd_addr_r) ? CW'(NV_READ_CYC - 1) : '0;
      end else if (ext_busy) begin
        if (!ext_end) begin
          ext_cnt_r <= ext_cnt_r - CW'(1);
        end else if (ext_write_busy_r) begin
          ext_write_busy_r <= 1'b0;
          ext_write_done_r <= 1'b1;
        end else begin
          ext_read_busy_r <= 1'b0;
          ext_read_done_r <= 1'b1;
          if (ext_rd_nv_r) begin
            {ext_read_upper_half_r, ext_read_lower_half_r} <= nv_mem[erd_addr_r[4:0]];
          end else if (in_sh(erd_addr_r)) begin
            {ext_read_upper_half_r, ext_read_lower_half_r} <= sh_mem[erd_addr_r[4:0]];
          end else begin
            {ext_read_upper_half_r, ext_read_lower_half_r} <= 32'h0000_0000;
          end
        end
      end
    end
  end

  // memory updates: write completion and nvm-to-shadow copies
  always_ff @(posedge clk_sys) begin
    if (ext_write_busy_r && ext_end && write_ok) begin
      if (ext_wr_nv_r) nv_mem[ewr_addr_r[4:0]] <= {ext_write_upper_half_r, ext_write_lower_half_r};
      else sh_mem[ewr_addr_r[4:0]] <= {ext_write_upper_half_r, ext_write_lower_half_r};
    end else if (nv_to_shadow) begin
      for (int i = 0; i < 32; i++) begin
        sh_mem[i] <= nv_mem[i];
      end
    end
  end

  // unlock key sequence; any wrong value restarts the count
  logic [7:0] key_expect;
  assign key_expect = KEY_SEQ[8*(4 - key_idx_r) +: 8];
  always_ff @(posedge clk_sys) begin
    if (sys_rst || hard_reset_end) begin
      key_idx_r            <= 3'd0;
      user_unlocked_flag_r <= 1'b0;
    end else if (wr_hit && reg_req.addr == OFS_KEY) begin
      if (reg_req.wdata[15:8] == key_expect && key_idx_r == 3'd4) begin
        user_unlocked_flag_r <= 1'b1;
        key_idx_r            <= 3'd0;
      end else if (reg_req.wdata[15:8] == key_expect) begin
        key_idx_r <= key_idx_r + 3'd1;
      end else begin
        key_idx_r <= reg_req.wdata[15:8] == KEY_SEQ[39:32] ? 3'd1 : 3'd0;
      end
    end
  end

  // sticky errors: set wins over a wipe in the same cycle
  logic [15:0] err_set;
  logic [15:0] warn_set;
  always_comb begin
    err_set              = 16'h0000;
    err_set[BIT_E_RST]   = hard_reset_end;
    err_set[BIT_E_MSL]   = field_low_in;
    err_set[BIT_E_UVA]   = uv_sync2_r[0];
    err_set[BIT_E_UVD]   = uv_sync2_r[1];
    err_set[BIT_E_STF]   = selftest_fail;
    warn_set                = 16'h0000;
    warn_set[BIT_W_OVERLAP] = (launch_wr || launch_rd) && ext_busy;
    warn_set[BIT_W_XFAIL]   = launch_ext_write && !write_ok;
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      err_r       <= 16'h0001;
      err_seen_r  <= 16'h0000;
      warn_r      <= 16'h0000;
      warn_seen_r <= 16'h0000;
    end else begin
      if (wr_hit && reg_req.addr == OFS_ACT_CTRL && reg_req.wdata[BIT_WIPE_ERR]) begin
        err_r      <= (err_r & ~err_seen_r) | err_set;
        err_seen_r <= 16'h0000;
      end else begin
        err_r <= err_r | err_set;
        if (rd_hit && reg_req.addr == OFS_FAULTS) err_seen_r <= err_r;
      end
      if (wr_hit && reg_req.addr == OFS_ACT_CTRL && reg_req.wdata[BIT_WIPE_WARN]) begin
        warn_r      <= (warn_r & ~warn_seen_r) | warn_set;
        warn_seen_r <= 16'h0000;
      end else begin
        warn_r <= warn_r | warn_set;
        if (rd_hit && reg_req.addr == OFS_WARNS) warn_seen_r <= warn_r;
      end
    end
  end

  // direction with hysteresis: reference moves only after a full step
  logic [11:0] ang_delta;
  assign ang_delta = angle_in - rot_ref_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      turn_direction_r <= 1'b0;
      rot_ref_r        <= 12'h000;
    end else if (!ang_delta[11] && ang_delta >= ROT_HYST) begin
      turn_direction_r <= 1'b0;
      rot_ref_r        <= angle_in;
    end else if (ang_delta[11] && (12'h000 - ang_delta) >= ROT_HYST) begin
      turn_direction_r <= 1'b1;
      rot_ref_r        <= angle_in;
    end
  end

  // summary bits and read words
  logic [15:0] err_view;
  logic        warn_any;
  logic        fault_summary_flag;
  logic        undervoltage_summary;
  logic [15:0] angle_word;
  logic [15:0] cond_word;
  logic [15:0] rd_mux;
  assign warn_any             = |(warn_r & ~warn_mask);
  assign err_view             = {TAG_FAULTS, warn_any, err_r[10:0]};
  assign fault_summary_flag   = |(err_r[10:0] & ~err_mask[10:0]) | warn_any;
  assign undervoltage_summary = (uv_sync2_r[0] & ~err_mask[BIT_E_UVA]) |
                                (uv_sync2_r[1] & ~err_mask[BIT_E_UVD]);
  always_comb begin
    angle_word                = {1'b0, fault_summary_flag, undervoltage_summary, 1'b0, angle_in};
    angle_word[BIT_PARITY]    = ~(^angle_word);
    cond_word                 = {TAG_COND, 2'b00, nv_mem[31][1:0], 8'h00};
    cond_word[BIT_ROT]        = turn_direction_r;
    cond_word[BIT_SDN]        = action_done_r;
    cond_word[BIT_BDN]        = boot_done_r;
    cond_word[BIT_LBR]        = act_state_r != ACT_IDLE && act_sel_r[1];
    cond_word[BIT_TRANSDUCER_SELFTEST_RUNNING]       = act_state_r != ACT_IDLE && act_sel_r[0] && act_sel_r[3];
    cond_word[BIT_BIP]        = boot_running_r;
    cond_word[BIT_AOK]        = angle_lock;
    case (reg_req.addr)
      OFS_EWR_ADDR:  rd_mux = {8'h00, ewr_addr_r};
      OFS_EWR_UPPER: rd_mux = ext_write_upper_half_r;
      OFS_EWR_LOWER: rd_mux = ext_write_lower_half_r;
      OFS_EWR_CTRL:  rd_mux = {7'h00, ext_write_busy_r, 7'h00, ext_write_done_r};
      OFS_ERD_ADDR:  rd_mux = {8'h00, erd_addr_r};
      OFS_ERD_CTRL:  rd_mux = {7'h00, ext_read_busy_r, 7'h00, ext_read_done_r};
      OFS_ERD_UPPER: rd_mux = ext_read_upper_half_r;
      OFS_ERD_LOWER: rd_mux = ext_read_lower_half_r;
      OFS_ACT_CTRL:  rd_mux = {act_sel_r, 12'h000};
      OFS_ANGLE:     rd_mux = angle_word;
      OFS_COND:      rd_mux = cond_word;
      OFS_FAULTS:    rd_mux = err_view;
      OFS_WARNS:     rd_mux = {TAG_WARNS, warn_r[11:0]};
      OFS_KEY:       rd_mux = {15'h0000, user_unlocked_flag_r};
      default:       rd_mux = 16'h0000;
    endcase
  end

  // registered outputs
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata        <= 16'h0000;
      reg_rvalid       <= 1'b0;
      margin_mode      <= 2'b00;
      core_reset_pulse <= 1'b0;
    end else begin
      reg_rdata        <= rd_hit ? rd_mux : 16'h0000;
      reg_rvalid       <= rd_hit;
      margin_mode      <= (act_sel_r == ACT_MARG_LO || act_sel_r == ACT_MARG_HI) ? act_sel_r[1:0] : 2'b00;
      core_reset_pulse <= hard_reset_end;
    end
  end
endmodule // ssrb_top

// file: sim/ssrb_properties.sv
module ssrb_properties
  import ssrb_pkg::*;
#(
  parameter int NV_WR_CYCLES = 50
) (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire ssrb_req_s   reg_req,
  input wire logic [11:0] angle_in,
  input wire logic        analog_uv_pin,
  input wire logic        digital_uv_pin,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic [1:0]  margin_mode,
  input wire logic        core_reset_pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // a read request at one register offset
  sequence s_rd(logic [5:0] a);
    reg_req.rd && reg_req.addr == a;
  endsequence
  // both supplies quiet long enough to pass the two-flop sync
  sequence s_uv_quiet;
    (!analog_uv_pin && !digital_uv_pin) [*4];
  endsequence
  AST_RVALID_ON_READ: assert property (reg_req.rd |=> reg_rvalid) else $error("read not answered");
  AST_IDLE_QUIET: assert property (!reg_req.rd |=> !reg_rvalid && reg_rdata == 16'h0000) else $error("stray read data");
  AST_ANGLE_VALUE: assert property (s_rd(OFS_ANGLE) |=> reg_rdata[11:0] == $past(angle_in))
    else $error("angle field wrong");
  AST_ANGLE_PARITY: assert property (s_rd(OFS_ANGLE) |=> ^reg_rdata == 1'b1) else $error("angle parity even");
  AST_UV_QUIET: assert property (s_uv_quiet ##0 s_rd(OFS_ANGLE) |=> !reg_rdata[13])
    else $error("undervoltage summary without cause");
  AST_WR_CTRL_READ: assert property (s_rd(OFS_EWR_CTRL) |=> !reg_rdata[15] && !(reg_rdata[8] && reg_rdata[0]))
    else $error("write control readback wrong");
  AST_RD_CTRL_READ: assert property (s_rd(OFS_ERD_CTRL) |=> !reg_rdata[15] && !(reg_rdata[8] && reg_rdata[0]))
    else $error("read control readback wrong");
  AST_ACT_LOW_ZERO: assert property (s_rd(OFS_ACT_CTRL) |=> reg_rdata[10:0] == 11'h000)
    else $error("trigger or strobes read nonzero");
  AST_KEY_ZERO: assert property (s_rd(OFS_KEY) |=> reg_rdata[15:1] == 15'h0000) else $error("key field nonzero");
  AST_MARGIN_CODE: assert property (margin_mode != 2'b11) else $error("margin mode illegal");
  AST_PULSE_SINGLE: assert property (core_reset_pulse |=> !core_reset_pulse [*8]) else $error("reset pulse too long");
endmodule // ssrb_properties

bind ssrb_top ssrb_properties #(.NV_WR_CYCLES(NV_WR_CYCLES)) u_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .reg_req(reg_req), .angle_in(angle_in), .analog_uv_pin(analog_uv_pin), .digital_uv_pin(digital_uv_pin),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .margin_mode(margin_mode), .core_reset_pulse(core_reset_pulse));

// file: sim/ssrb_host_model.sv
module ssrb_host_model
  import ssrb_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid,
  output ssrb_req_s        reg_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial reg_req = '0;
  // one request per call, held across the taking edge; released fields are inverted, not left stale
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [15:0] d, output logic [15:0] q);
    @(negedge clk_sys);
    reg_req = '{wr: wr, rd: ~wr, addr: a, wdata: d};
    @(negedge clk_sys);
    q = reg_rvalid ? reg_rdata : 16'hxxxx;
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // both data halves and the target go in before the launch
  task automatic ext_wr(input logic [7:0] a, input logic [31:0] d);
    logic [15:0] q;
    xfer(1'b1, OFS_EWR_UPPER, d[31:16], q);
    xfer(1'b1, OFS_EWR_LOWER, d[15:0], q);
    xfer(1'b1, OFS_EWR_ADDR, {8'h00, a}, q);
    xfer(1'b1, OFS_EWR_CTRL, 16'h8000, q);
  endtask
endmodule // ssrb_host_model

// file: sim/tb_sensor_serial_register_bank.sv
module tb_sensor_serial_register_bank;
  import ssrb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [11:0] angle_in = 12'h123;
  logic        analog_uv = 1'b0;
  logic [15:0] q, reg_rdata;
  logic        reg_rvalid, pulse;
  logic [1:0]  margin_mode;
  ssrb_req_s   reg_req;
  int          err_total = 0;
  int          checked = 0;
  always #50 clk_sys = ~clk_sys;
  ssrb_top #(.NV_WR_CYCLES(50)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_req(reg_req), .angle_in(angle_in),
    .angle_lock(1'b1), .field_low_in(1'b0), .analog_uv_pin(analog_uv), .digital_uv_pin(1'b0), .selftest_fail(1'b0),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .margin_mode(margin_mode), .core_reset_pulse(pulse));
  ssrb_host_model u_host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_req(reg_req));
  task automatic final_report;
    $display("errors %0d comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [5:0] a);
    u_host.xfer(1'b0, a, 16'h0000, q);
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask
  // bounded wait for a bit to read one; running out ends the run
  task automatic poll(input logic [5:0] a, input int b);
    for (int n = 0; n < 400; n++) begin
      rd(a);
      if (q[b] === 1'b1) return;
    end
    err_total++;
    $display("MISMATCH %0t poll timeout", $time);
    final_report();
  endtask
  task automatic t_reset_unlock;
    // boot copies nvm over shadow; wait it out so the mask word written later survives
    poll(OFS_COND, 4);
    rd(OFS_FAULTS);
    cmp(q & 16'h0001, 16'h0001);
    wr(OFS_ACT_CTRL, 16'h0100);
    rd(OFS_FAULTS);
    cmp(q & 16'h0001, 16'h0000);
    for (int i = 0; i < 5; i++) wr(OFS_KEY, {KEY_SEQ[39-8*i -: 8], 8'h00});
    rd(OFS_KEY);
    cmp(q, 16'h0001);
  endtask
  task automatic t_ext_access;
    u_host.ext_wr(8'h40, 32'h0000_0000);
    poll(OFS_EWR_CTRL, 0);
    u_host.ext_wr(8'h41, 32'h1234_5678);
    poll(OFS_EWR_CTRL, 0);
    wr(OFS_ERD_ADDR, 16'h0041);
    wr(OFS_ERD_CTRL, 16'h8000);
    poll(OFS_ERD_CTRL, 0);
    rd(OFS_ERD_UPPER);
    cmp(q, 16'h1234);
    rd(OFS_ERD_LOWER);
    cmp(q, 16'h5678);
    u_host.ext_wr(8'h05, 32'hCAFE_0001);
    rd(OFS_EWR_CTRL);
    cmp(q, 16'h0100);
    wr(OFS_ERD_CTRL, 16'h8000);
    rd(OFS_WARNS);
    cmp(q & 16'h0004, 16'h0004);
    poll(OFS_EWR_CTRL, 0);
  endtask
  task automatic t_angle_flags;
    rd(OFS_FAULTS);
    rd(OFS_WARNS);
    wr(OFS_ACT_CTRL, 16'h0300);
    rd(OFS_ANGLE);
    cmp(q, 16'h1123);
    analog_uv = 1'b1;
    repeat (4) @(negedge clk_sys);
    rd(OFS_ANGLE);
    cmp(q & 16'h6000, 16'h6000);
    analog_uv = 1'b0;
    repeat (4) @(negedge clk_sys);
    rd(OFS_ANGLE);
    cmp(q & 16'h6000, 16'h4000);
    angle_in = 12'h100;
    @(negedge clk_sys);
    rd(OFS_COND);
    cmp(q & 16'h0080, 16'h0080);
  endtask
  task automatic t_actions;
    wr(OFS_ACT_CTRL, 16'h0400);
    wr(OFS_ACT_CTRL, 16'hA000);
    wr(OFS_ACT_CTRL, 16'hA0A5);
    repeat (70) @(negedge clk_sys);
    rd(OFS_COND);
    cmp(q & 16'h0020, 16'h0000);
    wr(OFS_ACT_CTRL, 16'hA0B9);
    poll(OFS_COND, 5);
    rd(OFS_ACT_CTRL);
    cmp(q, 16'h0000);
    rd(OFS_ERD_ADDR);
    cmp(q, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_ACT_CTRL, {2'b00, 2'((i + 1) % 3), 12'h000});
      // margin output follows the select register one clock later
      @(negedge clk_sys);
      cmp({14'h0, margin_mode}, 16'((i + 1) % 3));
    end
  endtask
  task automatic t_hard_reset;
    int n;
    wr(OFS_ACT_CTRL, 16'h7000);
    wr(OFS_ACT_CTRL, 16'h705A);
    for (n = 0; n < 200 && pulse !== 1'b1; n++) @(negedge clk_sys);
    cmp({15'h0, pulse}, 16'h0001);
    poll(OFS_COND, 4);
    rd(OFS_FAULTS);
    cmp(q & 16'h0001, 16'h0001);
    u_host.ext_wr(8'h42, 32'h0000_0001);
    poll(OFS_EWR_CTRL, 0);
    rd(OFS_WARNS);
    cmp(q & 16'h0080, 16'h0080);
  endtask
  // reset, then the scenarios in order
  initial begin
    repeat (12) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_reset_unlock();
    t_ext_access();
    t_angle_flags();
    t_actions();
    t_hard_reset();
    final_report();
  end
endmodule // tb_sensor_serial_register_bank
